// File: ssf_pkg.sv
package ssf_pkg;
	// Register byte offsets
	localparam logic [7:0] SSF_STATUS_OFS = 8'h00;
	localparam logic [7:0] SSF_DATA_OFS = 8'h04;
	localparam logic [7:0] SSF_CTRL1_OFS = 8'h08;
	localparam logic [7:0] SSF_CTRL2_OFS = 8'h0c;
	localparam logic [7:0] SSF_EVT_STAT_OFS = 8'h10;
	localparam logic [7:0] SSF_EVT_CLR_OFS = 8'h14;
	localparam logic [7:0] SSF_EVT_EN_OFS = 8'h18;
	// Status flag positions
	localparam int SSF_TXE_BIT = 7;
	localparam int SSF_TXD_BIT = 6;
	localparam int SSF_RXF_BIT = 5;
	localparam int SSF_IDLE_BIT = 4;
	localparam int SSF_OVR_BIT = 3;
	localparam int SSF_NOISE_BIT = 2;
	localparam int SSF_FRM_BIT = 1;
	localparam int SSF_PAR_BIT = 0;
	// Control one / two enable positions
	localparam int SSF_PIE_BIT = 0;
	localparam int SSF_TIE_BIT = 7;
	localparam int SSF_TX_DONE_IRQ_ENABLE_BIT = 6;
	localparam int SSF_RIE_BIT = 5;
	localparam int SSF_IDLE_IRQ_ENABLE_BIT = 4;
	// Reset values
	localparam logic [7:0] SSF_STATUS_RST = 8'hc0;
	localparam logic [7:0] SSF_CTRL_RST = 8'h00;
	localparam logic [7:0] SSF_EVT_RST = 8'h00;
	localparam logic [8:0] SSF_DATA_RST = 9'h000;
endpackage

// File: ssf_status_flags.sv
`timescale 1ns/1ps
// Overview of operation
// - Transmit-empty flag, bit 7, sets when holding data moves to shifter.
// - Transmit-empty flag with its enable raises the interrupt.
// - Status access then data write clears transmit-empty and done flags.
// - Done flag, bit 6, sets after a data frame; never after preamble/break.
// - Done flag with its enable raises the interrupt.
// - Receive-ready flag, bit 5, sets on buffer copy; receive enable interrupts.
// - Receive-side flags except parity clear only on status access then data read.
// - Idle flag, bit 4, sets on idle line; idle enable interrupts.
// - Once cleared, idle re-arms only after a new receive-ready.
// - Overrun flag, bit 3, sets when a word arrives while receive-ready.
// - On overrun the holding buffer keeps the earlier word.
// - Noise flag, bit 2, sets on noisy frame; no own interrupt.
// - Framing flag, bit 1, sets on desync, noise or break; no interrupt.
// - Framing fault together with overrun sets only overrun.
// - Parity flag, bit 0, interrupts with its enable; clears on pair.
// - All enabled events except noise and framing share one interrupt line.
// - Receive enable interrupts on overrun or receive-ready.
module ssf_status_flags
	import ssf_pkg::*;
(
	input wire logic clk_i,
	input wire logic rst_i,
	// Wishbone classic slave
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	// Transmitter machine
	input wire logic tx_load_i,
	input wire logic tx_frame_done_i,
	input wire logic tx_frame_data_i,
	output logic [8:0] tx_data_o,
	output logic tx_data_valid_o,
	// Receiver machine
	input wire logic rx_word_done_i,
	input wire logic [8:0] rx_word_i,
	input wire logic rx_noise_i,
	input wire logic rx_framing_i,
	input wire logic rx_parity_i,
	input wire logic rx_idle_i,
	output logic [8:0] rx_data_o,
	// Shared interrupt request
	output logic irq_o
);

	//------------------------------------------------------------
	// Bus decode
	//------------------------------------------------------------
	logic ack_q;
	logic [31:0] rdat_q;
	logic acc;
	logic wr;
	logic rd;
	logic status_acc;
	logic data_wr;
	logic data_rd;
	logic seen_q;
	logic [7:0] flags_q;
	logic [7:0] flags_d;
	logic [7:0] ctrl1_q;
	logic [7:0] ctrl2_q;
	logic [7:0] evt_q;
	logic [7:0] evt_en_q;
	logic [7:0] evt_set;
	logic [8:0] txbuf_q;
	logic [8:0] rxbuf_q;
	logic idle_arm_q;
	logic irq_q;
	logic overrun;
	logic accept;
	logic tx_clr;
	logic rx_clr;
	logic par_clr;
	logic irq_d;
	logic tx_valid_q;
	logic [7:0] evt_irq;

	// A request is taken once; the ack cycle does not repeat it
	assign acc = wb_cyc_i & wb_stb_i & ~ack_q;
	assign wr = acc & wb_we_i & wb_sel_i[0];
	assign rd = acc & ~wb_we_i;
	assign status_acc = acc & (wb_adr_i == SSF_STATUS_OFS);
	assign data_wr = wr & (wb_adr_i == SSF_DATA_OFS);
	assign data_rd = rd & (wb_adr_i == SSF_DATA_OFS);

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			ack_q <= 1'b0;
		else
			ack_q <= acc;
	end

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			rdat_q <= 32'h0000_0000;
		else if (rd)
		begin
			unique case (wb_adr_i)
				SSF_STATUS_OFS: rdat_q <= {24'h00_0000, flags_q};
				SSF_DATA_OFS: rdat_q <= {23'h00_0000, rxbuf_q};
				SSF_CTRL1_OFS: rdat_q <= {24'h00_0000, ctrl1_q};
				SSF_CTRL2_OFS: rdat_q <= {24'h00_0000, ctrl2_q};
				SSF_EVT_STAT_OFS: rdat_q <= {24'h00_0000, evt_q};
				SSF_EVT_EN_OFS: rdat_q <= {24'h00_0000, evt_en_q};
				default: rdat_q <= 32'h0000_0000;
			endcase
		end
	end

	assign wb_ack_o = ack_q;
	assign wb_dat_o = rdat_q;

	//------------------------------------------------------------
	// Control registers
	//------------------------------------------------------------
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			ctrl1_q <= SSF_CTRL_RST;
			ctrl2_q <= SSF_CTRL_RST;
			evt_en_q <= SSF_EVT_RST;
		end
		else if (wr)
		begin
			if (wb_adr_i == SSF_CTRL1_OFS)
				ctrl1_q <= wb_dat_i[7:0];
			if (wb_adr_i == SSF_CTRL2_OFS)
				ctrl2_q <= wb_dat_i[7:0];
			if (wb_adr_i == SSF_EVT_EN_OFS)
				evt_en_q <= wb_dat_i[7:0];
		end
	end

	//------------------------------------------------------------
	// Clearing sequence
	//------------------------------------------------------------
	// Any status access arms; the next data access consumes the arm
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			seen_q <= 1'b0;
		else if (status_acc)
			seen_q <= 1'b1;
		else if (data_wr | data_rd)
			seen_q <= 1'b0;
	end

	assign tx_clr = seen_q & data_wr;
	assign rx_clr = seen_q & data_rd;
	assign par_clr = seen_q & (data_wr | data_rd);

	//------------------------------------------------------------
	// Data buffers
	//------------------------------------------------------------
	assign overrun = rx_word_done_i & flags_q[SSF_RXF_BIT];
	assign accept = rx_word_done_i & ~flags_q[SSF_RXF_BIT];

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			txbuf_q <= SSF_DATA_RST;
		else if (data_wr)
			txbuf_q <= {wb_sel_i[1] & wb_dat_i[8], wb_dat_i[7:0]};
	end

	// Overrun leaves the earlier word in place
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			rxbuf_q <= SSF_DATA_RST;
		else if (accept)
			rxbuf_q <= rx_word_i;
	end

	assign tx_data_o = txbuf_q;
	assign rx_data_o = rxbuf_q;

	//------------------------------------------------------------
	// Status flags
	//------------------------------------------------------------
	// Set wins over clear so an event in the clearing cycle survives
	always_comb
	begin
		flags_d = flags_q;
		if (tx_clr)
		begin
			flags_d[SSF_TXE_BIT] = 1'b0;
			flags_d[SSF_TXD_BIT] = 1'b0;
		end
		if (rx_clr)
		begin
			flags_d[SSF_RXF_BIT] = 1'b0;
			flags_d[SSF_IDLE_BIT] = 1'b0;
			flags_d[SSF_OVR_BIT] = 1'b0;
			flags_d[SSF_NOISE_BIT] = 1'b0;
			flags_d[SSF_FRM_BIT] = 1'b0;
		end
		if (par_clr)
			flags_d[SSF_PAR_BIT] = 1'b0;
		if (tx_load_i)
			flags_d[SSF_TXE_BIT] = 1'b1;
		if (tx_frame_done_i & tx_frame_data_i)
			flags_d[SSF_TXD_BIT] = 1'b1;
		if (accept)
		begin
			flags_d[SSF_RXF_BIT] = 1'b1;
			if (rx_noise_i)
				flags_d[SSF_NOISE_BIT] = 1'b1;
			if (rx_framing_i)
				flags_d[SSF_FRM_BIT] = 1'b1;
			if (rx_parity_i)
				flags_d[SSF_PAR_BIT] = 1'b1;
		end
		if (overrun)
			flags_d[SSF_OVR_BIT] = 1'b1;
		if (rx_idle_i & idle_arm_q)
			flags_d[SSF_IDLE_BIT] = 1'b1;
	end

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			flags_q <= SSF_STATUS_RST;
		else
			flags_q <= flags_d;
	end

	// One idle report per reception
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			idle_arm_q <= 1'b1;
		else if (accept)
			idle_arm_q <= 1'b1;
		else if (rx_idle_i)
			idle_arm_q <= 1'b0;
	end

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			tx_valid_q <= ~SSF_STATUS_RST[SSF_TXE_BIT];
		else
			tx_valid_q <= ~flags_d[SSF_TXE_BIT];
	end

	assign tx_data_valid_o = tx_valid_q;

	//------------------------------------------------------------
	// Event capture and interrupt
	//------------------------------------------------------------
	assign evt_set = flags_d & ~flags_q;

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			evt_q <= SSF_EVT_RST;
		else if (wr & (wb_adr_i == SSF_EVT_CLR_OFS))
			evt_q <= (evt_q & ~wb_dat_i[7:0]) | evt_set;
		else
			evt_q <= evt_q | evt_set;
	end

	// Noise and framing only accompany receive-ready, never interrupt alone
	always_comb
	begin
		evt_irq = evt_q & evt_en_q;
		evt_irq[SSF_NOISE_BIT] = 1'b0;
		evt_irq[SSF_FRM_BIT] = 1'b0;
	end

	// Noise and framing ride on receive-ready and have no enable
	always_comb
	begin
		irq_d = |evt_irq;
		irq_d = irq_d | (flags_q[SSF_TXE_BIT] & ctrl2_q[SSF_TIE_BIT]);
		irq_d = irq_d | (flags_q[SSF_TXD_BIT] & ctrl2_q[SSF_TX_DONE_IRQ_ENABLE_BIT]);
		irq_d = irq_d | ((flags_q[SSF_RXF_BIT] | flags_q[SSF_OVR_BIT])
			& ctrl2_q[SSF_RIE_BIT]);
		irq_d = irq_d | (flags_q[SSF_IDLE_BIT] & ctrl2_q[SSF_IDLE_IRQ_ENABLE_BIT]);
		irq_d = irq_d | (flags_q[SSF_PAR_BIT] & ctrl1_q[SSF_PIE_BIT]);
	end

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			irq_q <= 1'b0;
		else
			irq_q <= irq_d;
	end

	assign irq_o = irq_q;

	//------------------------------------------------------------
	// Checks
	//------------------------------------------------------------
	chk_txe_set: assert property (@(posedge clk_i) disable iff (rst_i)
		tx_load_i |=> flags_q[SSF_TXE_BIT])
		else $error("transmit-empty not set after load");

	chk_tx_clear: assert property (@(posedge clk_i) disable iff (rst_i)
		(tx_clr & ~tx_load_i & ~tx_frame_done_i)
		|=> ~flags_q[SSF_TXE_BIT] & ~flags_q[SSF_TXD_BIT])
		else $error("transmit flags survived clearing pair");

	chk_txd_data: assert property (@(posedge clk_i) disable iff (rst_i)
		(~flags_q[SSF_TXD_BIT] & ~(tx_frame_done_i & tx_frame_data_i))
		|=> ~flags_q[SSF_TXD_BIT])
		else $error("done flag set without a data frame");

	chk_rx_keep: assert property (@(posedge clk_i) disable iff (rst_i)
		overrun |=> $stable(rxbuf_q) && flags_q[SSF_OVR_BIT])
		else $error("overrun disturbed holding buffer");

	chk_frm_ovr: assert property (@(posedge clk_i) disable iff (rst_i)
		(overrun & rx_framing_i & ~flags_q[SSF_FRM_BIT])
		|=> ~flags_q[SSF_FRM_BIT])
		else $error("framing set together with overrun");

	chk_rx_hold: assert property (@(posedge clk_i) disable iff (rst_i)
		(flags_q[SSF_RXF_BIT] & ~data_rd) |=> flags_q[SSF_RXF_BIT])
		else $error("receive-ready dropped without data read");

	chk_idle_once: assert property (@(posedge clk_i) disable iff (rst_i)
		(rx_idle_i & ~accept) ##1 (~accept & ~flags_q[SSF_IDLE_BIT])
		|=> ~flags_q[SSF_IDLE_BIT])
		else $error("idle reported twice without reception");

	chk_irq_rx: assert property (@(posedge clk_i) disable iff (rst_i)
		(flags_q[SSF_OVR_BIT] & ctrl2_q[SSF_RIE_BIT]) |=> irq_o)
		else $error("overrun with receive enable gave no interrupt");

	chk_irq_quiet: assert property (@(posedge clk_i) disable iff (rst_i)
		((ctrl1_q == 8'h00) & (ctrl2_q == 8'h00) & (evt_en_q == 8'h00))
		|=> ~irq_o)
		else $error("interrupt with every enable clear");

	chk_irq_txe: assert property (@(posedge clk_i) disable iff (rst_i)
		(flags_q[SSF_TXE_BIT] & ctrl2_q[SSF_TIE_BIT]) |=> irq_o)
		else $error("transmit-empty with enable gave no interrupt");

	chk_irq_txd: assert property (@(posedge clk_i) disable iff (rst_i)
		(flags_q[SSF_TXD_BIT] & ctrl2_q[SSF_TX_DONE_IRQ_ENABLE_BIT]) |=> irq_o)
		else $error("done flag with enable gave no interrupt");

	chk_rxf_set: assert property (@(posedge clk_i) disable iff (rst_i)
		accept |=> flags_q[SSF_RXF_BIT] && (rxbuf_q == $past(rx_word_i)))
		else $error("accepted word not flagged or not buffered");

	chk_idle_set: assert property (@(posedge clk_i) disable iff (rst_i)
		(rx_idle_i & idle_arm_q) |=> flags_q[SSF_IDLE_BIT])
		else $error("armed idle line not reported");

	chk_rx_clear: assert property (@(posedge clk_i) disable iff (rst_i)
		(rx_clr & ~rx_word_done_i & ~rx_idle_i)
		|=> ((flags_q & 8'h3e) == 8'h00))
		else $error("receive flags survived clearing pair");

	chk_irq_par: assert property (@(posedge clk_i) disable iff (rst_i)
		(flags_q[SSF_PAR_BIT] & ctrl1_q[SSF_PIE_BIT]) |=> irq_o)
		else $error("parity with enable gave no interrupt");

	chk_irq_event: assert property (@(posedge clk_i) disable iff (rst_i)
		(|(evt_q & evt_en_q & 8'hf9)) |=> irq_o)
		else $error("enabled event gave no interrupt");

	chk_nf_quiet: assert property (@(posedge clk_i) disable iff (rst_i)
		(((flags_q & 8'hf9) == 8'h00) & ((evt_q & 8'hf9) == 8'h00))
		|=> ~irq_o)
		else $error("noise or framing raised an interrupt alone");

	chk_ack_pulse: assert property (@(posedge clk_i) disable iff (rst_i)
		wb_ack_o |=> ~wb_ack_o)
		else $error("ack held for two cycles");

endmodule // ssf_status_flags

// File: ssf_line_model.sv
`timescale 1ns/1ps
// ------------------------------------------------
// Far-side transmitter and receiver machines
// ------------------------------------------------
module ssf_line_model
(
	input wire logic clk_i,
	output logic [3:0] strobe_o,
	output logic [8:0] rx_word_o,
	output logic [2:0] rx_qual_o,
	output logic tx_frame_data_o
);
	initial
	begin
		strobe_o = 4'h0;
		rx_word_o = 9'h000;
		rx_qual_o = 3'h0;
		tx_frame_data_o = 1'b0;
	end
	// Strobes: load, frame done, word done, idle; each lasts one cycle.
	// Qualifiers are inverted afterwards so stale values are never reused.
	task pulse(input logic [3:0] s, input logic [8:0] w = 9'h000,
		input logic [2:0] q = 3'h0, input logic fd = 1'b0);
		@(posedge clk_i);
		strobe_o <= s;
		rx_word_o <= w;
		rx_qual_o <= q;
		tx_frame_data_o <= fd;
		@(posedge clk_i);
		strobe_o <= 4'h0;
		rx_word_o <= ~w;
		rx_qual_o <= ~q;
		tx_frame_data_o <= ~fd;
	endtask
endmodule // ssf_line_model

// File: test_ssf_status_flags.sv
`timescale 1ns/1ps
module test_ssf_status_flags
	import ssf_pkg::*;
;
	logic clk_i, rst_i, cyc, stb, we, ack, irq, tdv, tfa;
	logic [7:0] adr;
	logic [31:0] dat, dat_o, q;
	logic [8:0] txd, rxd, rw;
	logic [3:0] st, sel;
	logic [2:0] rq;
	int errors, samples_checked;
	ssf_status_flags uut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc),
		.wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
		.wb_dat_i(dat), .wb_dat_o(dat_o), .wb_ack_o(ack),
		.tx_load_i(st[3]), .tx_frame_done_i(st[2]), .tx_frame_data_i(tfa),
		.tx_data_o(txd), .tx_data_valid_o(tdv), .rx_word_done_i(st[1]),
		.rx_word_i(rw), .rx_noise_i(rq[2]), .rx_framing_i(rq[1]),
		.rx_parity_i(rq[0]), .rx_idle_i(st[0]), .rx_data_o(rxd),
		.irq_o(irq));
	ssf_line_model p (.clk_i(clk_i), .strobe_o(st), .rx_word_o(rw),
		.rx_qual_o(rq), .tx_frame_data_o(tfa));
	// ------------------------------------------------
	// Bus tasks and checks
	// ------------------------------------------------
	task chk(input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp)
		begin
			errors++;
			$display("Error at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask
	// Classic cycle; the watchdog ends a wait for an ack that never comes
	task wbs(input logic w, input logic [7:0] a, input logic [31:0] d,
		input logic [3:0] s);
		@(posedge clk_i);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		dat <= d;
		sel <= s;
		do @(posedge clk_i); while (ack !== 1'b1);
		q = dat_o;
		cyc <= 1'b0;
		stb <= 1'b0;
	endtask
	task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
		wbs(w, a, d, 4'hf);
	endtask
	task rd(input logic [7:0] a, input logic [31:0] e);
		wb(1'b0, a, 32'h0);
		chk(q, e);
	endtask
	task irqc(input logic e);
		repeat (3) @(posedge clk_i);
		chk({31'h0, irq}, {31'h0, e});
	endtask
	task close_out;
		$display("checks %0d errors %0d", samples_checked, errors);
		if (errors == 0 && samples_checked > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	initial
	begin
		clk_i = 1'b0;
		forever #2.5 clk_i = ~clk_i;
	end
	initial
	begin
		#20000;
		errors++;
		close_out;
	end
	// ------------------------------------------------
	// Test sequence
	// ------------------------------------------------
	initial
	begin
		{rst_i, cyc, stb, we, adr, dat} = {1'b1, 43'h0};
		errors = 0;
		samples_checked = 0;
		sel = 4'hf;
		repeat (6) @(posedge clk_i);
		rst_i <= 1'b0;
		rd(SSF_STATUS_OFS, 32'hc0);
		rd(SSF_CTRL1_OFS, 32'h0);
		rd(8'hfc, 32'h0);
		wbs(1'b1, SSF_CTRL1_OFS, 32'h1, 4'he);
		rd(SSF_CTRL1_OFS, 32'h0);
		wb(1'b1, SSF_CTRL2_OFS, 32'h80);
		irqc(1'b1);
		wb(1'b1, SSF_DATA_OFS, 32'h1a5);
		rd(SSF_STATUS_OFS, 32'h0);
		chk({23'h0, txd}, 32'h1a5);
		chk({31'h0, tdv}, 32'h1);
		rd(SSF_STATUS_OFS, 32'h0);
		wbs(1'b1, SSF_DATA_OFS, 32'h1a5, 4'h1);
		chk({23'h0, txd}, 32'h0a5);
		irqc(1'b0);
		p.pulse(4'h8);
		rd(SSF_STATUS_OFS, 32'h80);
		chk({31'h0, tdv}, 32'h0);
		p.pulse(4'h4);
		rd(SSF_STATUS_OFS, 32'h80);
		p.pulse(4'h4, 9'h000, 3'h0, 1'b1);
		rd(SSF_STATUS_OFS, 32'hc0);
		wb(1'b1, SSF_CTRL2_OFS, 32'h40);
		irqc(1'b1);
		wb(1'b1, SSF_DATA_OFS, 32'h0);
		rd(SSF_STATUS_OFS, 32'h0);
		irqc(1'b0);
		$display("tx test done");
		wb(1'b1, SSF_CTRL2_OFS, 32'h20);
		p.pulse(4'h2, 9'h055);
		rd(SSF_STATUS_OFS, 32'h20);
		irqc(1'b1);
		p.pulse(4'h2, 9'h0aa, 3'h2);
		rd(SSF_STATUS_OFS, 32'h28);
		chk({23'h0, rxd}, 32'h55);
		wb(1'b1, SSF_DATA_OFS, 32'h0);
		rd(SSF_STATUS_OFS, 32'h28);
		rd(SSF_DATA_OFS, 32'h55);
		rd(SSF_STATUS_OFS, 32'h0);
		irqc(1'b0);
		wb(1'b1, SSF_CTRL2_OFS, 32'h0);
		p.pulse(4'h2, 9'h1c3, 3'h7);
		rd(SSF_STATUS_OFS, 32'h27);
		irqc(1'b0);
		wb(1'b1, SSF_CTRL1_OFS, 32'h1);
		irqc(1'b1);
		rd(SSF_DATA_OFS, 32'h1c3);
		rd(SSF_STATUS_OFS, 32'h0);
		wb(1'b1, SSF_CTRL1_OFS, 32'h0);
		$display("rx test done");
		wb(1'b1, SSF_CTRL2_OFS, 32'h10);
		p.pulse(4'h1);
		rd(SSF_STATUS_OFS, 32'h10);
		irqc(1'b1);
		rd(SSF_DATA_OFS, 32'h1c3);
		p.pulse(4'h1);
		rd(SSF_STATUS_OFS, 32'h0);
		p.pulse(4'h2, 9'h011);
		p.pulse(4'h1);
		rd(SSF_STATUS_OFS, 32'h30);
		rd(SSF_DATA_OFS, 32'h11);
		wb(1'b1, SSF_CTRL2_OFS, 32'h0);
		wb(1'b1, SSF_EVT_CLR_OFS, 32'hff);
		rd(SSF_EVT_STAT_OFS, 32'h0);
		p.pulse(4'h2, 9'h022);
		rd(SSF_EVT_STAT_OFS, 32'h20);
		wb(1'b1, SSF_EVT_EN_OFS, 32'h20);
		rd(SSF_EVT_EN_OFS, 32'h20);
		irqc(1'b1);
		wb(1'b1, SSF_EVT_CLR_OFS, 32'h20);
		irqc(1'b0);
		rd(SSF_STATUS_OFS, 32'h20);
		rd(SSF_DATA_OFS, 32'h22);
		wb(1'b1, SSF_EVT_EN_OFS, 32'h06);
		p.pulse(4'h2, 9'h0c3, 3'h6);
		irqc(1'b0);
		$display("idle and event test done");
		close_out;
	end
endmodule // test_ssf_status_flags
